// file: hw/hpms_regs.vh
// Purpose: constants for the host port pin mode select block
// Assumes: 50 MHz system clock
// Notes:   mode codes and word width
`ifndef HPMS_REGS_VH
`define HPMS_REGS_VH
`define HPMS_MODE_PAR   2'h0
`define HPMS_MODE_4W    2'h1
`define HPMS_MODE_2W    2'h2
`define HPMS_WORD_W     24
`define HPMS_PAR_W      12
`define HPMS_CNT_W      5
`endif

// file: hw/hpms_fifo.v
// Purpose: small write queue with valid/ready on both sides
// Assumes: single clock
// Notes:   storage in flip-flops, depth a power of two
module hpms_fifo #(
   parameter WIDTH = 24,
   parameter DEPTH = 4,
   parameter AW    = 2
) (
   input  wire             i_clk,     // Clock
   input  wire             i_rst_b,   // Async reset, low
   input  wire             i_flush,   // Empty the queue
   input  wire             i_valid,   // Write valid
   output wire             o_ready,   // Space free
   input  wire [WIDTH-1:0] i_data,    // Write word
   output wire             o_valid,   // Word available
   input  wire             i_ready,   // Drain accept
   output wire [WIDTH-1:0] o_data     // Head word
);
   reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
   reg [AW-1:0]    wr_reg;
   reg [AW-1:0]    rd_reg;
   reg [AW:0]      cnt_reg;
   wire            push;
   wire            pop;

   // Honest full and empty from the count
   assign o_ready = (cnt_reg != DEPTH[AW:0]);
   assign o_valid = (cnt_reg != {(AW+1){1'b0}});
   assign o_data  = mem_reg[rd_reg];
   assign push    = i_valid & o_ready;
   assign pop     = o_valid & i_ready;

   // Pointers and count
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         wr_reg  <= {AW{1'b0}};
         rd_reg  <= {AW{1'b0}};
         cnt_reg <= {(AW+1){1'b0}};
      end else if (i_flush) begin
         wr_reg  <= {AW{1'b0}};
         rd_reg  <= {AW{1'b0}};
         cnt_reg <= {(AW+1){1'b0}};
      end else begin
         if (push) wr_reg <= wr_reg + 1'b1;
         if (pop) rd_reg <= rd_reg + 1'b1;
         if (push & ~pop) cnt_reg <= cnt_reg + 1'b1;
         else if (pop & ~push) cnt_reg <= cnt_reg - 1'b1;
      end
   end

   // Storage, no reset needed on data
   always @(posedge i_clk) begin
      if (push) mem_reg[wr_reg] <= i_data;
   end
endmodule // hpms_fifo

// file: hw/hpms_top.v
// Purpose: host port pin mode select with serial capture and write queue
// Assumes: serial clocks sampled by i_clk; serial clock well below i_clk / 4
// Notes:   two-wire mode captures bytes only; protocol decode lies outside
`include "hpms_regs.vh"
module hpms_top #(
   parameter WORD_W = `HPMS_WORD_W,
   parameter DEPTH  = 4
) (
   input  wire              i_clk,        // 50 MHz clock
   input  wire              i_rst_b,      // Async reset, low
   input  wire              i_host_port_type_select, // 1 = serial
   input  wire              i_reset_pin_b,   // Device reset pin, low
   input  wire              i_clear_input_b, // Clear pin, low
   input  wire              i_busy_b,     // Busy, low = interfaces off
   input  wire              i_queue_en,   // Write queue enable pin
   input  wire              i_sync_b,     // Four-wire frame select, low
   input  wire              i_wr_b,       // Parallel write strobe, low
   input  wire [`HPMS_PAR_W-1:0] i_par_data, // Data pins, bits 11..0
   input  wire              i_data_bit_12_clock_pin, // Serial clock pin
   input  wire              i_data_bit_10_clock_pin, // Unused clock alias
   input  wire [WORD_W-1:0] i_rb_word,    // Readback word
   input  wire              i_rb_load,    // Load readback word
   output reg               o_sdo,        // Four-wire serial out
   output reg               o_sdo_oe,     // Serial out enable
   output reg               o_sda_o,      // Two-wire data out (low only)
   output reg               o_sda_oe,     // High while pulling low
   input  wire              i_ack_req,    // Request ack pull-down
   output reg  [1:0]        o_mode,       // Selected port mode
   output reg               o_queue_on,   // Queue enabled
   output reg               o_word_valid, // Word out valid
   output reg  [WORD_W-1:0] o_word,       // Word out
   input  wire              i_word_ready, // Consumer ready
   output reg               o_wr_ready    // Queue can take a write
);
   // Two-flop synchronisers for every pin
   localparam NS = 8;
   reg [NS-1:0] s1_reg;
   reg [NS-1:0] s2_reg;
   reg          sclk_d_reg;
   reg          wr_d_reg;
   reg          clr_d_reg;
   reg          rst_d_reg;
   reg [2:0]    first_reg;    // Walks a one to the edge after the pins settle
   reg          qen1_reg;     // Queue enable pin, first stage
   reg          qen2_reg;     // Queue enable pin, second stage
   reg [`HPMS_PAR_W-1:0] pd1_reg; // Data pins, first stage
   reg [`HPMS_PAR_W-1:0] pd2_reg; // Data pins, second stage
   wire ser   = s2_reg[0];
   wire sel9  = s2_reg[1];
   wire sclk  = s2_reg[2];
   wire sdin  = s2_reg[3];
   wire busy_b= s2_reg[4];
   wire wr_b  = s2_reg[5];
   wire clr_b = s2_reg[6];
   wire rst_b = s2_reg[7];
   wire [NS-1:0] pins = {i_reset_pin_b, i_clear_input_b, i_wr_b, i_busy_b,
                         i_par_data[11], i_data_bit_12_clock_pin,
                         i_par_data[9], i_host_port_type_select};

   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         // Reset values equal the idle pin levels, so no false edge follows reset
         s1_reg   <= 8'hFC;
         s2_reg   <= 8'hFC;
         qen1_reg <= 1'b0;
         qen2_reg <= 1'b0;
         pd1_reg  <= {`HPMS_PAR_W{1'b0}};
         pd2_reg  <= {`HPMS_PAR_W{1'b0}};
      end else begin
         s1_reg   <= pins;
         s2_reg   <= s1_reg;
         qen1_reg <= i_queue_en;
         qen2_reg <= qen1_reg;
         pd1_reg  <= i_par_data;           // Same delay as the strobe
         pd2_reg  <= pd1_reg;
      end
   end

   // Edge detectors read only the second stage
   wire sclk_fall = sclk_d_reg & ~sclk;
   wire sclk_rise = ~sclk_d_reg & sclk;
   wire wr_rise   = ~wr_d_reg & wr_b;
   wire clr_fall  = clr_d_reg & ~clr_b;
   wire rst_fall  = rst_d_reg & ~rst_b;
   // Power-up sample waits until the synchronised pin holds a real level
   wire resample  = first_reg[2] | clr_fall | rst_fall;

   // Mode decode; bit 10 alias is left unused by choice
   reg [1:0] mode_next;
   always @* begin
      if (!ser) mode_next = `HPMS_MODE_PAR;
      else if (!sel9) mode_next = `HPMS_MODE_4W;
      else mode_next = `HPMS_MODE_2W;
   end

   // Frame select for four-wire mode
   reg [1:0] sy1_reg;
   wire sync_b = sy1_reg[1];
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) sy1_reg <= 2'h3;
      else sy1_reg <= {sy1_reg[0], i_sync_b};
   end

   // Shift state and queue feed
   reg [WORD_W-1:0]     sh_reg;
   reg [`HPMS_CNT_W-1:0] cnt_reg;
   reg [WORD_W-1:0]     rb_reg;
   reg                  push_reg;
   reg [WORD_W-1:0]     push_data_reg;
   reg [7:0]            b_reg;
   reg [3:0]            bcnt_reg;
   wire q_ready;
   wire q_valid;
   wire [WORD_W-1:0] q_data;
   wire active = busy_b;
   wire q_use  = o_queue_on & (o_mode == `HPMS_MODE_PAR);

   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sclk_d_reg   <= 1'b1;
         wr_d_reg     <= 1'b1;
         clr_d_reg    <= 1'b1;
         rst_d_reg    <= 1'b1;
         first_reg    <= 3'h1;
         o_mode       <= `HPMS_MODE_PAR;
         o_queue_on   <= 1'b0;
         sh_reg       <= {WORD_W{1'b0}};
         cnt_reg      <= {`HPMS_CNT_W{1'b0}};
         rb_reg       <= {WORD_W{1'b0}};
         push_reg     <= 1'b0;
         push_data_reg<= {WORD_W{1'b0}};
         b_reg        <= 8'h00;
         bcnt_reg     <= 4'h0;
         o_sdo        <= 1'b0;
         o_sdo_oe     <= 1'b0;
         o_sda_o      <= 1'b0;
         o_sda_oe     <= 1'b0;
         o_wr_ready   <= 1'b0;
      end else begin
         sclk_d_reg <= sclk;
         wr_d_reg   <= wr_b;
         clr_d_reg  <= clr_b;
         rst_d_reg  <= rst_b;
         first_reg  <= {first_reg[1:0], 1'b0};
         o_mode     <= mode_next;
         push_reg   <= 1'b0;
         // Latch queue enable at power-up, clear and reset; serial mode forces it off
         if (resample)
            o_queue_on <= qen2_reg & ~ser;
         else
            o_queue_on <= o_queue_on & ~ser;
         o_wr_ready <= q_use ? q_ready : 1'b1;
         o_sdo_oe   <= active & (o_mode == `HPMS_MODE_4W) & ~sync_b;
         o_sda_o    <= 1'b0;
         o_sda_oe   <= active & (o_mode == `HPMS_MODE_2W) & i_ack_req;
         if (i_rb_load) rb_reg <= i_rb_word;
         if (!active) begin
            cnt_reg  <= {`HPMS_CNT_W{1'b0}};
            bcnt_reg <= 4'h0;
         end else if (o_mode == `HPMS_MODE_PAR) begin
            if (wr_rise) begin
               push_reg      <= 1'b1;
               push_data_reg <= {{(WORD_W-`HPMS_PAR_W){1'b0}}, pd2_reg};
            end
         end else if (o_mode == `HPMS_MODE_4W) begin
            // Between frames the first readback bit waits on the pin for the first fall
            if (sync_b) begin
               cnt_reg <= {`HPMS_CNT_W{1'b0}};
               o_sdo   <= rb_reg[WORD_W-1];
            end else if (sclk_fall) begin
               sh_reg <= {sh_reg[WORD_W-2:0], sdin};
               if (cnt_reg == WORD_W[`HPMS_CNT_W-1:0] - 1'b1) begin
                  cnt_reg       <= {`HPMS_CNT_W{1'b0}};
                  push_reg      <= 1'b1;
                  push_data_reg <= {sh_reg[WORD_W-2:0], sdin};
               end else cnt_reg <= cnt_reg + 1'b1;
            end
            if (sclk_rise & ~sync_b) begin
               o_sdo  <= rb_reg[WORD_W-2];                 // Next bit, MSB already out
               rb_reg <= {rb_reg[WORD_W-2:0], 1'b0};
            end
         end else begin
            // Host clock rate is free, any rate well below i_clk / 4; the bench runs a 160 ns clock
            if (sclk_rise) begin
               b_reg <= {b_reg[6:0], sdin};
               if (bcnt_reg == 4'h7) begin
                  bcnt_reg      <= 4'h0;
                  push_reg      <= 1'b1;
                  push_data_reg <= {{(WORD_W-8){1'b0}}, b_reg[6:0], sdin};
               end else bcnt_reg <= bcnt_reg + 1'b1;
            end
         end
      end
   end

   // Queue only in parallel mode with queue enabled; else bypass
   wire bypass_ready = ~o_word_valid | i_word_ready;
   hpms_fifo #(.WIDTH(WORD_W), .DEPTH(DEPTH), .AW(2)) u_fifo (
      .i_clk   (i_clk),
      .i_rst_b (i_rst_b),
      .i_flush (~q_use),
      .i_valid (push_reg & q_use),
      .o_ready (q_ready),
      .i_data  (push_data_reg),
      .o_valid (q_valid),
      .i_ready (q_use & bypass_ready),
      .o_data  (q_data)
   );

   // Output word register, drained by consumer
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_word_valid <= 1'b0;
         o_word       <= {WORD_W{1'b0}};
      end else if (bypass_ready) begin
         if (q_use) begin
            o_word_valid <= q_valid;
            o_word       <= q_data;
         end else begin
            o_word_valid <= push_reg;
            o_word       <= push_data_reg;
         end
      end
   end
endmodule // hpms_top

// file: bench/hpms_top_checker.sv
// Purpose: port checks for the host pin mode select
// Assumes: mode pins change only while in reset
// Notes:   bound to every hpms_top, names matched
`include "hpms_regs.vh"
module hpms_top_checker #(
   parameter WORD_W = 24
) (
   input logic              i_clk,                   // Clock
   input logic              i_rst_b,                 // Reset, low
   input logic              i_host_port_type_select, // Serial
   input logic [11:0]       i_par_data,              // Data pins
   input logic              i_busy_b,                // Busy, low
   input logic              i_queue_en,              // Queue pin
   input logic              i_word_ready,            // Consumer
   input logic              i_data_bit_12_clock_pin, // Serial clock
   input logic [1:0]        o_mode,                  // Mode
   input logic              o_queue_on,              // Queue on
   input logic              o_sda_o,                 // Two-wire out
   input logic              o_sda_oe,                // Pull low
   input logic              o_sdo_oe,                // Readback on
   input logic              o_word_valid,            // Valid
   input logic [WORD_W-1:0] o_word                   // Word
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   logic [4:0] since_fall_reg; // Cycles since the serial clock fell
   // Saturates so an old edge never looks recent
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) since_fall_reg <= 5'h1f;
      else if ($fell(i_data_bit_12_clock_pin)) since_fall_reg <= 5'h00;
      else if (since_fall_reg != 5'h1f) since_fall_reg <= since_fall_reg + 5'h01;
   end
   // Mode pins held long enough to pass the synchronisers
   sequence s_4w; (i_host_port_type_select && !i_par_data[9]) [*6]; endsequence
   sequence s_2w; (i_host_port_type_select && i_par_data[9]) [*6]; endsequence
   mode_parallel_a: assert property ((!i_host_port_type_select) [*6] |-> o_mode == 2'h0)
      else $error("parallel mode not selected");
   mode_four_wire_a: assert property (s_4w |-> o_mode == `HPMS_MODE_4W)
      else $error("four-wire mode not selected");
   mode_two_wire_a: assert property (s_2w |-> o_mode == `HPMS_MODE_2W)
      else $error("two-wire mode not selected");
   queue_serial_a: assert property (o_mode != 2'h0 |-> !o_queue_on)
      else $error("queue on in serial mode");
   queue_latch_a: assert property ($changed(o_queue_on) |->
      o_queue_on == ($past(i_queue_en, 3) && !$past(i_host_port_type_select, 3)))
      else $error("queue state not from pin");
   sda_drain_a: assert property (o_sda_oe |-> !o_sda_o && o_mode == `HPMS_MODE_2W)
      else $error("data line driven high or out of mode");
   sdo_mode_a: assert property (o_sdo_oe |-> o_mode == `HPMS_MODE_4W)
      else $error("readback driven out of mode");
   busy_quiet_a: assert property ((!i_busy_b) [*8] |-> !$rose(o_word_valid))
      else $error("word taken while busy");
   word_hold_a: assert property (o_word_valid && !i_word_ready |=> o_word_valid && $stable(o_word))
      else $error("word dropped before ready");
   word_clock_a: assert property ($rose(o_word_valid) && o_mode == 2'h1 |-> since_fall_reg <= 5'h14)
      else $error("word without a falling clock");
endmodule // hpms_top_checker
bind hpms_top hpms_top_checker #(.WORD_W(WORD_W)) u_hpms_top_checker (.*);

// file: bench/hpms_host_model.sv
// Purpose: host model driving the serial clock and data pins
// Assumes: clock rests high between frames
// Notes:   data moves only on the half away from the capture edge
module hpms_host_model (
   output logic o_sclk,   // Serial clock
   output logic o_sync_b, // Frame select, low
   output logic o_din,    // Serial data
   input  logic i_sdo     // Readback from the block
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle levels
   initial begin
      o_sclk = 1'b1;
      o_sync_b = 1'b1;
      o_din = 1'b1;
   end
   // Four-wire frame, MSB first, 160 ns clock
   task automatic send_4w(input logic [23:0] w, output logic [23:0] r);
      r = 24'h00_0000;
      o_sync_b = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         o_din = w[i];
         #80 o_sclk = 1'b0;
         r = {r[22:0], i_sdo}; // Readback taken on the falling edge
         #80 o_sclk = 1'b1;
      end
      #80 o_sync_b = 1'b1;
      o_din = ~w[0]; // Released line must not echo the last bit
   endtask
   // Two-wire byte on a 160 ns clock, data moved while the clock is low
   task automatic send_2w(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         #80 o_sclk = 1'b0;
         #20 o_din = b[i];
         #60 o_sclk = 1'b1;
      end
      #80 o_din = 1'b1; // Released, pull-up level
   endtask
endmodule // hpms_host_model

// file: bench/test_host_port_pin_mode_select.sv
// Purpose: self-checking bench for the host pin mode select
// Assumes: 50 MHz clock, host model on the serial pins
// Notes:   queue of 4 words, 24-bit words
`include "hpms_regs.vh"
module test_host_port_pin_mode_select;
   timeunit 1ns;
   timeprecision 1ns;
   logic        i_clk = 1'b0, rst_b = 1'b0, ser = 1'b0, qen = 1'b0, busy_b = 1'b1;
   logic        rstp_b = 1'b1, clr_b = 1'b1, wr_b = 1'b1, ack = 1'b0, rdy = 1'b0;
   logic        rb_ld = 1'b0, sclk, sync_b, din, sdo, sdo_oe, sda_o, sda_oe, q_on, vld, wr_rdy;
   logic [11:0] pins = 12'h000;
   logic [1:0]  mode;
   logic [23:0] word;
   logic [23:0] rb_got;
   wire  [11:0] pdata = {ser ? (din & ~sda_oe) : pins[11], pins[10:0]}; // Pulled-up data wire
   int          error_cnt = 0;
   int          n_tests = 0;
   always #10 i_clk = ~i_clk;
   // Bit 10 runs inverted so a design clocked from it captures garbage
   hpms_top u_hpms_top (.i_clk(i_clk), .i_rst_b(rst_b), .i_host_port_type_select(ser),
      .i_reset_pin_b(rstp_b), .i_clear_input_b(clr_b), .i_busy_b(busy_b), .i_queue_en(qen),
      .i_sync_b(sync_b), .i_wr_b(wr_b), .i_par_data(pdata), .i_data_bit_12_clock_pin(sclk),
      .i_data_bit_10_clock_pin(~sclk), .i_rb_word(24'h5a_c3f0), .i_rb_load(rb_ld),
      .o_sdo(sdo), .o_sdo_oe(sdo_oe), .o_sda_o(sda_o), .o_sda_oe(sda_oe), .i_ack_req(ack),
      .o_mode(mode), .o_queue_on(q_on), .o_word_valid(vld), .o_word(word),
      .i_word_ready(rdy), .o_wr_ready(wr_rdy));
   hpms_host_model u_hpms_host_model (.o_sclk(sclk), .o_sync_b(sync_b), .o_din(din),
      .i_sdo(sdo));
   task automatic step(input int n);
      repeat (n) @(posedge i_clk);
      #2;
   endtask
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Mode pins change only inside reset
   task automatic boot(input logic s, input logic b9, input logic q);
      rst_b = 1'b0;
      ser = s;
      qen = q;
      pins[9] = b9;
      step(6);
      rst_b = 1'b1;
      step(10);
   endtask
   // Bounded wait for a word, compare, then accept it
   task automatic get(input logic [23:0] exp);
      int k = 0;
      while (vld !== 1'b1 && k < 50) begin
         step(1);
         k++;
      end
      chk(24'(vld), 24'h1);
      chk(word, exp);
      rdy = 1'b1;
      step(1);
      rdy = 1'b0;
      step(1);
   endtask
   task automatic t_par();
      logic [11:0] d [5] = '{12'he00, 12'h2a5, 12'h45a, 12'h9ff, 12'h600};
      logic full = 1'b0;
      boot(1'b0, 1'b0, 1'b1);
      chk(24'(mode), 24'h0);
      chk(24'(q_on), 24'h1);
      foreach (d[i]) begin
         pins = d[i];
         wr_b = 1'b0;
         step(3);
         wr_b = 1'b1;
         step(8);
         full |= !wr_rdy;
      end
      chk(24'(full), 24'h1);
      foreach (d[i]) get(24'(d[i]));
      qen = 1'b0;
      step(10);
      chk(24'(q_on), 24'h1);
      clr_b = 1'b0;
      step(3);
      clr_b = 1'b1;
      step(10);
      chk(24'(q_on), 24'h0);
      qen = 1'b1;
      rstp_b = 1'b0;
      step(3);
      rstp_b = 1'b1;
      step(10);
      chk(24'(q_on), 24'h1);
   endtask
   task automatic t_4w();
      boot(1'b1, 1'b0, 1'b0);
      chk(24'(mode), 24'(`HPMS_MODE_4W));
      rb_ld = 1'b1;
      step(1);
      rb_ld = 1'b0;
      u_hpms_host_model.send_4w(24'ha5_c31e, rb_got);
      chk(rb_got, 24'h5a_c3f0);
      get(24'ha5_c31e);
      busy_b = 1'b0;
      u_hpms_host_model.send_4w(24'h3c_0ff1, rb_got);
      step(20);
      chk(24'(vld), 24'h0);
      busy_b = 1'b1;
      step(4);
      u_hpms_host_model.send_4w(24'h3c_0ff1, rb_got);
      get(24'h3c_0ff1);
   endtask
   task automatic t_2w();
      boot(1'b1, 1'b1, 1'b0);
      chk(24'(mode), 24'(`HPMS_MODE_2W));
      u_hpms_host_model.send_2w(8'hb4);
      get(24'h00_00b4);
      ack = 1'b1;
      step(6);
      chk(24'({sda_oe, pdata[11]}), 24'h2);
      ack = 1'b0;
      step(6);
      chk(24'(sda_oe), 24'h0);
   endtask
   task automatic complete_run();
      $display("checks %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Main sequence, and a watchdog well past its expected length
   initial begin
      t_par();
      t_4w();
      t_2w();
      complete_run();
   end
   initial begin
      #400000;
      error_cnt++;
      complete_run();
   end
endmodule // test_host_port_pin_mode_select
